// File: hdl/hrm_pkg.sv
package hrm_pkg;

   // ==========================================================
   // Bus and register map
   // ==========================================================
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int AXES = 8;
   localparam int AXIS_W = 3;
   localparam logic [ADDR_W-1:0] OFS_AMP_CFG = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_HR_REQ = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MODE_REQ = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_LAST = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_ERR_BASE = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_ERR_LAST = 8'h5C;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int CFG_COMM_DIGIT_BIT = 0;
   localparam int CFG_MARKER_BIT = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam int ST_W = 4;
   localparam int ST_HOME_BIT = 0;
   localparam int ST_MODE_BIT = 1;
   localparam int ST_ERR_BIT = 2;
   localparam int ST_STOP_BIT = 3;
   localparam logic [ST_W-1:0] MASK_RESET = 4'h0;
   localparam int ERR_W = 16;
   localparam int ERR_MODE_LSB = 16;

   // ==========================================================
   // Minor error codes
   // ==========================================================
   localparam logic [ERR_W-1:0] ERR_NONE = 16'h0000;
   localparam logic [ERR_W-1:0] ERR_ZPHASE = 16'h0078;
   localparam logic [ERR_W-1:0] ERR_METHOD = 16'h0085;
   localparam logic [ERR_W-1:0] ERR_TORQUE_INIT = 16'h009A;
   localparam logic [ERR_W-1:0] ERR_DRIVER_HR = 16'h00C2;
   localparam logic [ERR_W-1:0] ERR_CONT_TORQUE = 16'h013E;

   // ==========================================================
   // Enumerations
   // ==========================================================
   typedef enum logic [3:0] {
      HR_DOG1 = 4'h0, HR_DOG2 = 4'h1, HR_CNT1 = 4'h2, HR_CNT2 = 4'h3,
      HR_CNT3 = 4'h4, HR_DSET1 = 4'h5, HR_DSET2 = 4'h6, HR_CRADLE = 4'h7,
      HR_STOP1 = 4'h8, HR_STOP2 = 4'h9, HR_LIMIT = 4'hA, HR_SCALE = 4'hB,
      HR_DOGLESS = 4'hC, HR_DRIVER = 4'hD, HR_RSV_E = 4'hE, HR_RSV_F = 4'hF
   } hrm_method_type;

   typedef enum logic [1:0] {
      ENC_ABS_LINEAR = 2'h0, ENC_INC_LINEAR = 2'h1,
      ENC_ABS_DD = 2'h2, ENC_INC_DD = 2'h3
   } hrm_enc_type;

   typedef enum logic [1:0] {
      OP_NONE = 2'h0, OP_A = 2'h1, OP_B = 2'h2, OP_C = 2'h3
   } hrm_op_type;

   typedef enum logic [1:0] {
      MODE_POS = 2'h0, MODE_SPEED = 2'h1, MODE_TORQUE = 2'h2, MODE_CONT_TORQUE = 2'h3
   } hrm_mode_type;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic cond_sel;
      hrm_enc_type enc;
      logic zphase_passed;
      logic family;
      hrm_method_type method;
      logic [AXIS_W-1:0] axis;
   } hrm_hr_req_type;

   typedef struct packed {
      logic start;
      hrm_op_type op;
      logic retry;
      logic cond;
      logic [ERR_W-1:0] err;
   } hrm_hr_res_type;

   typedef struct packed {
      logic torque_init_sel;
      hrm_mode_type mode;
      logic [AXIS_W-1:0] axis;
   } hrm_mode_req_type;

   typedef struct packed {
      logic switch_ok;
      logic stop;
      logic [ERR_W-1:0] err;
   } hrm_mode_res_type;

   // Set wins over a write-one clear
   function automatic logic [ST_W-1:0] sticky(input logic [ST_W-1:0] cur,
                                               input logic [ST_W-1:0] set,
                                               input logic [ST_W-1:0] clr);
      return set | (cur & ~clr);
   endfunction

   function automatic logic [AXIS_W-1:0] err_index(input logic [ADDR_W-1:0] a);
      return a[AXIS_W+1:2];
   endfunction

endpackage

// File: hdl/hrm_home_check.sv
`timescale 1ns/1ps
module hrm_home_check (
   input hrm_pkg::hrm_hr_req_type req,
   input wire logic comm_digit,
   input wire logic marker_ok,
   output hrm_pkg::hrm_hr_res_type res
);
   always_comb begin
      res = '0;
      res.start = 1'b1;
      case (req.method)
         hrm_pkg::HR_DSET2, hrm_pkg::HR_STOP1, hrm_pkg::HR_STOP2,
         hrm_pkg::HR_RSV_E, hrm_pkg::HR_RSV_F: begin
            res.start = 1'b0; // RULE2
            res.err = hrm_pkg::ERR_METHOD; // RULE2
         end
         hrm_pkg::HR_DRIVER: begin
            res.start = 1'b0; // RULE3
            res.err = hrm_pkg::ERR_DRIVER_HR; // RULE3
         end
         hrm_pkg::HR_DOGLESS: begin
            case (req.enc)
               hrm_pkg::ENC_ABS_LINEAR: begin
                  res.op = hrm_pkg::OP_C; // RULE4
                  res.retry = 1'b0;
                  res.cond = 1'b0;
               end
               hrm_pkg::ENC_ABS_DD: begin
                  res.op = req.cond_sel ? hrm_pkg::OP_B : hrm_pkg::OP_A; // RULE4
                  res.retry = ~req.cond_sel;
                  res.cond = req.cond_sel;
               end
               default: begin
                  res.op = hrm_pkg::OP_A; // RULE4
                  res.retry = 1'b1;
                  res.cond = 1'b0;
               end
            endcase
         end
         default: begin
            res.op = hrm_pkg::OP_A; // RULE1
         end
      endcase
      // Z phase gate only applies to methods that would otherwise start
      if (res.start && !req.zphase_passed) begin
         if ((!req.family && !comm_digit) || (req.family && !marker_ok)) begin
            res.start = 1'b0; // RULE5 RULE6
            res.err = hrm_pkg::ERR_ZPHASE; // RULE5 RULE6
         end
      end
      if (!res.start) begin
         res.op = hrm_pkg::OP_NONE;
         res.retry = 1'b0;
         res.cond = 1'b0;
      end
   end
endmodule // hrm_home_check

// File: hdl/hrm_mode_check.sv
`timescale 1ns/1ps
module hrm_mode_check (
   input hrm_pkg::hrm_mode_req_type req,
   output hrm_pkg::hrm_mode_res_type res
);
   always_comb begin
      res = '0;
      case (req.mode)
         hrm_pkg::MODE_CONT_TORQUE: begin
            res.stop = 1'b1; // RULE8
            res.err = hrm_pkg::ERR_CONT_TORQUE; // RULE8
         end
         default: begin
            res.switch_ok = 1'b1; // RULE7
            // Feedback torque unsupported: switch still proceeds
            if (req.torque_init_sel) begin
               res.err = hrm_pkg::ERR_TORQUE_INIT; // RULE9
            end
         end
      endcase
   end
endmodule // hrm_mode_check

// File: hdl/hrm_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Proximity dog 1/2, count 1-3, data set 1, dog cradle, limit combined, scale and dogless start.
// RULE2: Data set 2 and stopper 1/2 give minor error 133 and no home return.
// RULE3: Driver home return gives minor error 194 and no home return.
// RULE4: Dogless return picks operation, retry and condition from amplifier and encoder type.
// RULE5: First family returns without Z phase only if the comm mode select digit is 1, else error 120.
// RULE6: Second family returns without Z phase only if marker transit select allows, else error 120.
// RULE7: Position, speed and torque control modes are accepted.
// RULE8: Switching to continuous-operation-to-torque gives minor error 318 and stops the operation.
// RULE9: Torque initial selection 1 gives minor error 154 and command torque is used.
// RULE10: Each minor error is latched per axis in a readable location and flags an error event.
module hrm_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [hrm_pkg::ADDR_W-1:0] paddr,
   input wire logic [hrm_pkg::DATA_W-1:0] pwdata,
   output logic [hrm_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic hr_start,
   output logic [hrm_pkg::AXIS_W-1:0] hr_axis,
   output hrm_pkg::hrm_method_type hr_method,
   output hrm_pkg::hrm_op_type hr_op,
   output logic hr_retry,
   output logic hr_cond,
   output logic mode_switch,
   output logic [hrm_pkg::AXIS_W-1:0] mode_axis,
   output hrm_pkg::hrm_mode_type mode_sel,
   output logic torque_init_fb,
   output logic op_stop
);

   // ==========================================================
   // Storage
   // ==========================================================
   logic [1:0] cfg_q;
   hrm_pkg::hrm_hr_req_type hr_req_q;
   hrm_pkg::hrm_mode_req_type mode_req_q;
   logic hr_go_q;
   logic mode_go_q;
   logic [hrm_pkg::ST_W-1:0] status_q;
   logic [hrm_pkg::ST_W-1:0] status_d;
   logic [hrm_pkg::ST_W-1:0] mask_q;
   logic [hrm_pkg::ERR_W-1:0] err_q [hrm_pkg::AXES];
   hrm_pkg::hrm_mode_type cur_mode_q [hrm_pkg::AXES];
   logic [hrm_pkg::ERR_W-1:0] last_err_q;
   logic [hrm_pkg::DATA_W-1:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   logic hr_start_q;
   logic [hrm_pkg::AXIS_W-1:0] hr_axis_q;
   hrm_pkg::hrm_method_type hr_method_q;
   hrm_pkg::hrm_op_type hr_op_q;
   logic hr_retry_q;
   logic hr_cond_q;
   logic mode_switch_q;
   logic [hrm_pkg::AXIS_W-1:0] mode_axis_q;
   hrm_pkg::hrm_mode_type mode_sel_q;
   logic op_stop_q;
   logic torque_init_fb_q;

   hrm_pkg::hrm_hr_res_type hr_res;
   hrm_pkg::hrm_mode_res_type mode_res;

   // ==========================================================
   // Bus decode
   // ==========================================================
   logic access;
   logic wr_en;
   logic rd_phase;
   logic addr_ok;
   logic err_hit;
   logic [hrm_pkg::DATA_W-1:0] rdata_d;
   logic [hrm_pkg::ST_W-1:0] ev_set;
   logic [hrm_pkg::ST_W-1:0] ev_clr;
   logic hr_err_ev;
   logic mode_err_ev;

   assign access = psel && penable;
   // Writes land on the edge where pready is seen high
   assign wr_en = access && pwrite && pready_q;
   // One wait state keeps prdata and pready registered
   assign rd_phase = access && !pready_q;
   // One aligned error word per axis
   assign err_hit = (paddr >= hrm_pkg::OFS_ERR_BASE) && (paddr <= hrm_pkg::OFS_ERR_LAST)
                    && (paddr[1:0] == 2'h0);

   always_comb begin
      addr_ok = 1'b1;
      rdata_d = '0;
      case (paddr)
         hrm_pkg::OFS_AMP_CFG: begin
            rdata_d[1:0] = cfg_q;
         end
         hrm_pkg::OFS_HR_REQ: begin
            rdata_d[$bits(hrm_pkg::hrm_hr_req_type)-1:0] = hr_req_q;
         end
         hrm_pkg::OFS_MODE_REQ: begin
            rdata_d[$bits(hrm_pkg::hrm_mode_req_type)-1:0] = mode_req_q;
         end
         hrm_pkg::OFS_STATUS: begin
            rdata_d[hrm_pkg::ST_W-1:0] = status_q;
         end
         hrm_pkg::OFS_MASK: begin
            rdata_d[hrm_pkg::ST_W-1:0] = mask_q;
         end
         hrm_pkg::OFS_LAST: begin
            rdata_d[hrm_pkg::ERR_W-1:0] = last_err_q;
            rdata_d[hrm_pkg::ERR_MODE_LSB +: 2] = hr_op_q;
            rdata_d[hrm_pkg::ERR_MODE_LSB + 2] = hr_retry_q;
            rdata_d[hrm_pkg::ERR_MODE_LSB + 3] = hr_cond_q;
         end
         default: begin
            if (err_hit) begin
               rdata_d[hrm_pkg::ERR_W-1:0] = err_q[hrm_pkg::err_index(paddr)]; // RULE10
               rdata_d[hrm_pkg::ERR_MODE_LSB +: 2] = cur_mode_q[hrm_pkg::err_index(paddr)];
            end else begin
               addr_ok = 1'b0;
            end
         end
      endcase
   end

   // ==========================================================
   // APB answer
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= rd_phase;
         pslverr_q <= rd_phase && !addr_ok;
         if (rd_phase && !pwrite) begin
            prdata_q <= rdata_d;
         // Read data stands only in the pready cycle
         end else if (!access || pready_q) begin
            prdata_q <= '0;
         end
      end
   end

   // ==========================================================
   // Software registers
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= hrm_pkg::CFG_RESET;
         mask_q <= hrm_pkg::MASK_RESET;
      end else if (wr_en) begin
         if (paddr == hrm_pkg::OFS_AMP_CFG) begin
            cfg_q <= pwdata[1:0];
         end
         if (paddr == hrm_pkg::OFS_MASK) begin
            mask_q <= pwdata[hrm_pkg::ST_W-1:0];
         end
      end
   end

   // A write to a request register arms one check on the next edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hr_req_q <= '0;
         mode_req_q <= '0;
         hr_go_q <= 1'b0;
         mode_go_q <= 1'b0;
      end else begin
         hr_go_q <= wr_en && (paddr == hrm_pkg::OFS_HR_REQ);
         mode_go_q <= wr_en && (paddr == hrm_pkg::OFS_MODE_REQ);
         if (wr_en && (paddr == hrm_pkg::OFS_HR_REQ)) begin
            hr_req_q <= pwdata[$bits(hrm_pkg::hrm_hr_req_type)-1:0];
         end
         if (wr_en && (paddr == hrm_pkg::OFS_MODE_REQ)) begin
            mode_req_q <= pwdata[$bits(hrm_pkg::hrm_mode_req_type)-1:0];
         end
      end
   end

   // ==========================================================
   // Checkers
   // ==========================================================
   hrm_home_check u_home (
      .req(hr_req_q),
      .comm_digit(cfg_q[hrm_pkg::CFG_COMM_DIGIT_BIT]),
      .marker_ok(cfg_q[hrm_pkg::CFG_MARKER_BIT]),
      .res(hr_res)
   );

   hrm_mode_check u_mode (
      .req(mode_req_q),
      .res(mode_res)
   );

   assign hr_err_ev = hr_go_q && (hr_res.err != hrm_pkg::ERR_NONE);
   assign mode_err_ev = mode_go_q && (mode_res.err != hrm_pkg::ERR_NONE);

   // ==========================================================
   // Home return output
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hr_start_q <= 1'b0;
         hr_axis_q <= '0;
         hr_method_q <= hrm_pkg::HR_DOG1;
         hr_op_q <= hrm_pkg::OP_NONE;
         hr_retry_q <= 1'b0;
         hr_cond_q <= 1'b0;
      end else begin
         hr_start_q <= hr_go_q && hr_res.start; // RULE1 RULE2 RULE3
         if (hr_go_q) begin
            hr_axis_q <= hr_req_q.axis;
            hr_method_q <= hr_req_q.method;
            hr_op_q <= hr_res.op; // RULE4
            hr_retry_q <= hr_res.retry; // RULE4
            hr_cond_q <= hr_res.cond; // RULE4
         end
      end
   end

   // ==========================================================
   // Control mode output
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_switch_q <= 1'b0;
         mode_axis_q <= '0;
         mode_sel_q <= hrm_pkg::MODE_POS;
         op_stop_q <= 1'b0;
      end else begin
         mode_switch_q <= mode_go_q && mode_res.switch_ok; // RULE7
         op_stop_q <= mode_go_q && mode_res.stop; // RULE8
         if (mode_go_q) begin
            mode_axis_q <= mode_req_q.axis;
         end
         if (mode_go_q && mode_res.switch_ok) begin
            mode_sel_q <= mode_req_q.mode; // RULE7
         end
      end
   end

   // Only command torque is ever handed on after a switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         torque_init_fb_q <= 1'b0;
      end else begin
         if (mode_go_q) begin
            torque_init_fb_q <= 1'b0; // RULE9
         end
      end
   end

   // Current mode per axis; a refused switch leaves it unchanged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < hrm_pkg::AXES; i++) begin
            cur_mode_q[i] <= hrm_pkg::MODE_POS;
         end
      end else if (mode_go_q && mode_res.switch_ok) begin
         cur_mode_q[mode_req_q.axis] <= mode_req_q.mode; // RULE7 RULE8
      end
   end

   // ==========================================================
   // Per-axis error latch
   // ==========================================================
   // Mode error wins when both checks report on one axis in one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < hrm_pkg::AXES; i++) begin
            err_q[i] <= hrm_pkg::ERR_NONE;
         end
         last_err_q <= hrm_pkg::ERR_NONE;
      end else begin
         for (int i = 0; i < hrm_pkg::AXES; i++) begin
            if (mode_err_ev && (mode_req_q.axis == i[hrm_pkg::AXIS_W-1:0])) begin
               err_q[i] <= mode_res.err; // RULE8 RULE9 RULE10
            end else if (hr_err_ev && (hr_req_q.axis == i[hrm_pkg::AXIS_W-1:0])) begin
               err_q[i] <= hr_res.err; // RULE2 RULE3 RULE5 RULE6 RULE10
            end else if (wr_en && err_hit && (hrm_pkg::err_index(paddr) == i[hrm_pkg::AXIS_W-1:0])) begin
               err_q[i] <= hrm_pkg::ERR_NONE;
            end
         end
         if (mode_err_ev) begin
            last_err_q <= mode_res.err; // RULE10
         end else if (hr_err_ev) begin
            last_err_q <= hr_res.err; // RULE10
         end
      end
   end

   // ==========================================================
   // Events and interrupt
   // ==========================================================
   always_comb begin
      ev_set = '0;
      ev_set[hrm_pkg::ST_HOME_BIT] = hr_go_q && hr_res.start;
      ev_set[hrm_pkg::ST_MODE_BIT] = mode_go_q && mode_res.switch_ok;
      ev_set[hrm_pkg::ST_ERR_BIT] = hr_err_ev || mode_err_ev; // RULE10
      ev_set[hrm_pkg::ST_STOP_BIT] = mode_go_q && mode_res.stop;
      ev_clr = '0;
      if (wr_en && (paddr == hrm_pkg::OFS_STATUS)) begin
         ev_clr = pwdata[hrm_pkg::ST_W-1:0];
      end
      status_d = hrm_pkg::sticky(status_q, ev_set, ev_clr);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= '0;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_q <= |(status_d & mask_q);
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign hr_start = hr_start_q;
   assign hr_axis = hr_axis_q;
   assign hr_method = hr_method_q;
   assign hr_op = hr_op_q;
   assign hr_retry = hr_retry_q;
   assign hr_cond = hr_cond_q;
   assign mode_switch = mode_switch_q;
   assign mode_axis = mode_axis_q;
   assign mode_sel = mode_sel_q;
   assign torque_init_fb = torque_init_fb_q;
   assign op_stop = op_stop_q;

endmodule // hrm_top

// File: bench/hrm_top_monitor.sv
`timescale 1ns/1ps
module hrm_top_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [hrm_pkg::ADDR_W-1:0] paddr,
   input wire logic [hrm_pkg::DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic hr_start,
   input hrm_pkg::hrm_method_type hr_method,
   input hrm_pkg::hrm_op_type hr_op,
   input wire logic hr_retry,
   input wire logic mode_switch,
   input wire logic torque_init_fb,
   input wire logic op_stop
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr, hw, mw, bad;
   assign wr = psel & penable & pready & pwrite;
   assign hw = wr & (paddr == hrm_pkg::OFS_HR_REQ);
   assign mw = wr & (paddr == hrm_pkg::OFS_MODE_REQ);
   assign bad = pwdata[6:3] inside {4'h6, 4'h8, 4'h9, 4'hD, 4'hE, 4'hF};
   // ==========================================================
   // Properties
   // ==========================================================
   property p_pulse; pready |=> !pready; endproperty
   property p_acc; pready |-> psel && penable && $past(psel && penable); endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_refuse; hw && bad |-> ##2 !hr_start; endproperty
   property p_accept; hw && !bad && pwdata[8] |-> ##2 hr_start ##1 !hr_start; endproperty
   property p_opc;
      hr_start && hr_op == hrm_pkg::OP_C |-> hr_method == hrm_pkg::HR_DOGLESS && !hr_retry;
   endproperty
   property p_stop; mw && pwdata[4:3] == 2'h3 |-> ##2 op_stop && !mode_switch; endproperty
   property p_switch; mw && pwdata[4:3] != 2'h3 |-> ##2 mode_switch && !op_stop; endproperty
   property p_fb;
      mw && pwdata[5] && pwdata[4:3] != 2'h3 |-> ##2 mode_switch && !torque_init_fb;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
   a_acc: assert property (p_acc) else $error("pready outside access phase");
   a_err: assert property (p_err) else $error("pslverr without pready");
   a_refuse: assert property (p_refuse) else $error("refused method started");
   a_accept: assert property (p_accept) else $error("accepted method not started");
   a_opc: assert property (p_opc) else $error("operation C misuse");
   a_stop: assert property (p_stop) else $error("continuous torque not stopped");
   a_switch: assert property (p_switch) else $error("mode switch missing");
   a_fb: assert property (p_fb) else $error("feedback torque used");
   c_opb: cover property (hr_start && hr_op == hrm_pkg::OP_B);
   c_stop: cover property (op_stop);
   c_slverr: cover property (pslverr);
endmodule // hrm_top_monitor

bind hrm_top hrm_top_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .hr_start, .hr_method, .hr_op, .hr_retry, .mode_switch,
   .torque_init_fb, .op_stop);

// File: bench/hrm_amp_model.sv
`timescale 1ns/1ps
module hrm_amp_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hr_start,
   input hrm_pkg::hrm_op_type hr_op,
   input wire logic mode_switch,
   input wire logic op_stop,
   output int start_cnt_q,
   output int switch_cnt_q,
   output int bad_op_q
);
   // Amplifier only counts what it is told; a start with no operation is counted in bad_op_q
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_cnt_q <= 0;
         switch_cnt_q <= 0;
         bad_op_q <= 0;
      end else begin
         if (hr_start) start_cnt_q <= start_cnt_q + 1;
         if (hr_start && hr_op == hrm_pkg::OP_NONE) bad_op_q <= bad_op_q + 1;
         if (mode_switch || op_stop) switch_cnt_q <= switch_cnt_q + 1;
      end
   end
endmodule // hrm_amp_model

// File: bench/hrm_top_tb.sv
`timescale 1ns/1ps
module hrm_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, hr_start, hr_retry, hr_cond, mode_switch, torque_init_fb, op_stop;
   logic [2:0] hr_axis, mode_axis;
   hrm_pkg::hrm_method_type hr_method;
   hrm_pkg::hrm_op_type hr_op;
   hrm_pkg::hrm_mode_type mode_sel;
   int start_cnt_q, switch_cnt_q, bad_op_q;
   int error_cnt = 0, tests_run = 0, cyc = 0, seed = 64, n_start = 0;
   logic [32:0] exp_q[$];
   logic [1:0] mode_q[8];

   hrm_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq, .hr_start, .hr_axis, .hr_method, .hr_op, .hr_retry, .hr_cond,
      .mode_switch, .mode_axis, .mode_sel, .torque_init_fb, .op_stop);
   hrm_amp_model u_amp (.pclk, .presetn, .hr_start, .hr_op, .mode_switch, .op_stop,
      .start_cnt_q, .switch_cnt_q, .bad_op_q);

   always #12.5 pclk = ~pclk;

   task automatic results();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic ok, input string s);
      tests_run++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t %s", $time, s);
      end
   endtask

   // ==========================================================
   // Bus master: expected response queued before the request
   // ==========================================================
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      exp_q.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(negedge pclk); while (pready !== 1'b1);
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   always @(negedge pclk) begin
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) check(1'b0, "unexpected response");
         else check({pslverr, prdata} === exp_q.pop_front(), "bus response");
      end
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("ERROR %0t timeout", $time);
         results();
      end
   end

   // Request, then status and per-axis error, each cleared after reading
   task automatic req(input logic [7:0] a, input logic [11:0] w, input logic [15:0] c,
                      input logic [3:0] st);
      logic [7:0] ea;
      ea = 8'h40 | {3'h0, w[2:0], 2'h0};
      apb(1'b1, a, {20'h0, w}, 33'h0);
      apb(1'b0, 8'h0C, 32'h0, {29'h0, st});
      apb(1'b1, 8'h0C, 32'hF, 33'h0);
      apb(1'b0, ea, 32'h0, {15'h0, mode_q[w[2:0]], c});
      apb(1'b1, ea, 32'h0, 33'h0);
   endtask

   initial begin
      logic [2:0] ax;
      logic [15:0] c;
      logic [3:0] ex;
      logic [1:0] lm;
      mode_q = '{default: 2'h0};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0, 33'h0);
      apb(1'b0, 8'h10, 32'h0, 33'h0);
      apb(1'b1, 8'h24, 32'hFFFFFFFF, 33'h100000000);
      apb(1'b0, 8'h20, 32'h0, 33'h100000000);
      $display("test registers done");
      apb(1'b1, 8'h00, 32'h3, 33'h0);
      for (int m = 0; m < 16; m++) begin
         ax = 3'($random(seed));
         c = (m inside {6, 8, 9, 14, 15}) ? 16'h0085 : (m == 13) ? 16'h00C2 : 16'h0;
         if (c == 16'h0) n_start++;
         req(8'h04, {4'h1, 1'b0, 4'(m), ax}, c, (c == 16'h0) ? 4'h1 : 4'h4);
      end
      $display("test methods done");
      for (int e = 0; e < 8; e++) begin
         ax = 3'($random(seed));
         ex = (e[2:1] == 2'h0) ? 4'hC : (e == 5) ? 4'h9 : 4'h6;
         n_start++;
         req(8'h04, {e[0], e[2:1], 1'b1, 1'b0, 4'hC, ax}, 16'h0, 4'h1);
         check({hr_op, hr_retry, hr_cond, hr_axis, hr_method} === {ex, ax, 4'hC},
               "dogless choice");
      end
      $display("test dogless done");
      for (int k = 0; k < 8; k++) begin
         ax = 3'($random(seed));
         apb(1'b1, 8'h00, {30'h0, k[2:1]}, 33'h0);
         c = k[1 + k[0]] ? 16'h0 : 16'h0078;
         if (c == 16'h0) n_start++;
         req(8'h04, {4'h0, k[0], 4'h0, ax}, c, (c == 16'h0) ? 4'h1 : 4'h4);
      end
      $display("test z phase done");
      apb(1'b1, 8'h10, 32'h4, 33'h0);
      apb(1'b1, 8'h04, 32'h68, 33'h0);
      @(posedge pclk);
      check(irq === 1'b1, "irq not raised");
      apb(1'b1, 8'h0C, 32'h4, 33'h0);
      @(posedge pclk);
      check(irq === 1'b0, "irq not cleared");
      apb(1'b1, 8'h10, 32'h0, 33'h0);
      apb(1'b1, 8'h04, 32'h68, 33'h0);
      @(posedge pclk);
      check(irq === 1'b0, "masked irq raised");
      apb(1'b1, 8'h0C, 32'hF, 33'h0);
      apb(1'b1, 8'h40, 32'h0, 33'h0);
      $display("test interrupt done");
      for (int k = 0; k < 8; k++) begin
         ax = 3'($random(seed));
         if (k[2:1] != 2'h3) mode_q[ax] = k[2:1];
         lm = (k[2:1] != 2'h3) ? k[2:1] : lm;
         c = (k[2:1] == 2'h3) ? 16'h013E : k[0] ? 16'h009A : 16'h0;
         ex = (k[2:1] == 2'h3) ? 4'hC : k[0] ? 4'h6 : 4'h2;
         req(8'h08, {6'h0, k[0], k[2:1], ax}, c, ex);
         check({mode_sel, mode_axis} === {lm, ax}, "mode select");
      end
      $display("test modes done");
      check(start_cnt_q === n_start, "start count");
      check(switch_cnt_q === 8 && bad_op_q === 0, "amplifier count");
      check(exp_q.size() == 0, "responses missing");
      results();
   end
endmodule // hrm_top_tb
